// ==== pkg/bmx_pkg.sv ====
package bmx_pkg;

	// Bus phase codes reported by the core sequencer
	localparam logic [2:0] PH_IDLE = 3'h0;
	localparam logic [2:0] PH_T1   = 3'h1;
	localparam logic [2:0] PH_T2   = 3'h2;
	localparam logic [2:0] PH_T3   = 3'h3;
	localparam logic [2:0] PH_T4   = 3'h4;

	// Queue status codes, upper bit first
	localparam logic [1:0] QS_NOP    = 2'h0;
	localparam logic [1:0] QS_FIRST  = 2'h1;
	localparam logic [1:0] QS_FLUSH  = 2'h2;
	localparam logic [1:0] QS_SUBSEQ = 2'h3;

	// Pin levels
	localparam logic [2:0] STATUS_PASSIVE = 3'h7;
	localparam logic       LINE_IDLE      = 1'h1;
	localparam logic       LINE_PULSE     = 1'h0;
	localparam logic       PIN_HIGH       = 1'h1;
	localparam logic       MODE_MAX       = 1'h0;

	// Cycles a bus cycle may start after an idle-bus request
	localparam logic [1:0] IDLE_WINDOW = 2'h3;

	typedef enum logic [4:0] {
		ST_OWN   = 5'h01,
		ST_WAIT  = 5'h02,
		ST_PULSE = 5'h04,
		ST_GRANT = 5'h08,
		ST_GAP   = 5'h10
	} bmx_state_t;

endpackage

// ==== rtl/bmx_rg_line.sv ====
`timescale 1ns/1ps
// One request/grant line: pulse detector and grant pulse driver
module bmx_rg_line (
	// Clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_reset,
	// Line pin
	input  wire logic i_line,
	output logic      o_line,
	output logic      o_line_oe,
	// Control
	input  wire logic i_drive_next,
	output logic      o_pulse_seen
);

	logic prev_q;
	logic oe_q;

	// Own pulse must not read back as a request
	assign o_pulse_seen = prev_q & ~i_line & ~oe_q;
	assign o_line       = bmx_pkg::LINE_PULSE;
	assign o_line_oe    = oe_q;

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			prev_q <= bmx_pkg::LINE_IDLE;
			oe_q   <= 1'h0;
		end else begin
			prev_q <= i_line;
			oe_q   <= i_drive_next;
		end
	end

endmodule // bmx_rg_line

// ==== rtl/bmx_exchange.sv ====
`timescale 1ns/1ps
// What this block does
// - Grant is a one-clock low pulse in T4 or T1, bus floated, grant follows.
// - In grant the bus interface is disconnected and runs no transactions.
// - A third pulse ends tenure; bus reclaimed next clock into T4 or T1.
// - Each ownership exchange is exactly three low pulses: request, grant, release.
// - At least one idle clock passes after each exchange before the next pulse.
// - Release at T4 only if early request, not low byte, not first ack, unlocked.
// - Request on an idle bus releases the bus in the third clock after the request pulse.
// - Any bus cycle reaching T1 within 3 clocks of idle request counts as early.
// - Lock prefix drives lock low until the following instruction completes.
// - Lock output floats, reading as one, during grant.
// - Lock asserts at T2 of first interrupt ack, drops at T2 of second.
// - Queue status valid the cycle after its operation, never floated.
// - Queue codes: 00 none, 01 first byte, 10 emptied, 11 subsequent byte.
// - Constant-high pin drives one in maximum mode only, floats reading as one during grant.
// - Two request/grant lines, the first has priority, both pulled up.
// - Cycle status pins float at passive all-ones during grant.
// - Exchange, lock and queue behaviour only in maximum mode.
module bmx_exchange (
	// Clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_reset,
	// Mode strap, low selects maximum mode
	input  wire logic       i_min_max_select,
	// Core bus sequencer
	input  wire logic [2:0] i_bus_phase,
	input  wire logic       i_mem_cycle,
	input  wire logic       i_low_byte_of_word,
	input  wire logic       i_irq_ack_strobe,
	input  wire logic       i_irq_ack_first,
	input  wire logic       i_cycle_pending,
	input  wire logic [2:0] i_cycle_status,
	// Instruction flow
	input  wire logic       i_lock_prefix,
	input  wire logic       i_instr_done,
	input  wire logic       i_q_first,
	input  wire logic       i_q_subseq,
	input  wire logic       i_q_flush,
	// High priority request/grant line
	input  wire logic       i_req_grant_line_high_prio,
	output logic            o_req_grant_line_high_prio,
	output logic            o_req_grant_line_high_prio_oe,
	// Low priority request/grant line
	input  wire logic       i_req_grant_line_low_prio,
	output logic            o_req_grant_line_low_prio,
	output logic            o_req_grant_line_low_prio_oe,
	// Core handshake
	output logic            o_bus_float,
	output logic            o_reclaim_t4,
	output logic            o_reclaim_t1,
	// Lock pin
	output logic            o_lock_n,
	output logic            o_lock_oe,
	// Queue status pins
	output logic            o_queue_state_upper,
	output logic            o_queue_state_lower,
	// Cycle status pins
	output logic            o_cycle_status_bit_a,
	output logic            o_cycle_status_bit_b,
	output logic            o_cycle_status_bit_c,
	output logic            o_cycle_status_oe,
	// Constant-high pin
	output logic            o_const_high,
	output logic            o_const_high_oe
);

	function automatic logic [1:0] qs_encode(
		input logic first,
		input logic subseq,
		input logic flush
	);
		logic [1:0] code;
		code = bmx_pkg::QS_NOP;
		if (flush) begin
			code = bmx_pkg::QS_FLUSH;
		end else if (first) begin
			code = bmx_pkg::QS_FIRST;
		end else if (subseq) begin
			code = bmx_pkg::QS_SUBSEQ;
		end
		return code;
	endfunction

	bmx_pkg::bmx_state_t state_q;
	bmx_pkg::bmx_state_t state_d;

	logic       max_q;
	logic       pend_hp_q;
	logic       pend_hp_d;
	logic       pend_lp_q;
	logic       pend_lp_d;
	logic       sel_lp_q;
	logic       sel_lp_d;
	logic       early_q;
	logic       early_d;
	logic [1:0] win_q;
	logic [1:0] win_d;
	logic       ilock_q;
	logic       ilock_d;
	logic       alock_q;
	logic       alock_d;
	logic       bus_float_q;
	logic       reclaim_t4_q;
	logic       reclaim_t1_q;
	logic       lock_n_q;
	logic       lock_oe_q;
	logic [1:0] qs_q;
	logic [2:0] cs_q;
	logic       cs_oe_q;
	logic       high_oe_q;

	wire seen_hp;
	wire seen_lp;
	wire drive_hp;
	wire drive_lp;

	wire ph_idle  = (i_bus_phase == bmx_pkg::PH_IDLE);
	wire ph_t1    = (i_bus_phase == bmx_pkg::PH_T1);
	wire ph_t2    = (i_bus_phase == bmx_pkg::PH_T2);
	wire ph_t4    = (i_bus_phase == bmx_pkg::PH_T4);
	wire ph_early = ph_t1 | ph_t2;
	wire win_on   = (win_q != 2'h0);

	// A pulse on the granted line during grant is the release, not a request
	wire in_grant = (state_q == bmx_pkg::ST_GRANT);
	wire rel_seen = in_grant & (sel_lp_q ? seen_lp : seen_hp);
	wire req_hp   = seen_hp & ~(in_grant & ~sel_lp_q);
	wire req_lp   = seen_lp & ~(in_grant & sel_lp_q);
	wire any_req  = req_hp | req_lp;

	wire early_eff = early_q | (win_on & ph_t1);
	wire first_ack = i_irq_ack_strobe & i_irq_ack_first;

	// All four release conditions at the cycle end
	wire t4_ok = ph_t4 & early_eff & ~i_low_byte_of_word & ~first_ack & ~ilock_q;
	wire go    = ph_idle | t4_ok;

	wire float_d = (state_d == bmx_pkg::ST_PULSE) | (state_d == bmx_pkg::ST_GRANT);

	assign drive_hp = (state_d == bmx_pkg::ST_PULSE) & ~sel_lp_d;
	assign drive_lp = (state_d == bmx_pkg::ST_PULSE) & sel_lp_d;

	bmx_rg_line u_line_hp (
		.i_sys_clk    (i_sys_clk),
		.i_reset      (i_reset),
		.i_line       (i_req_grant_line_high_prio),
		.o_line       (o_req_grant_line_high_prio),
		.o_line_oe    (o_req_grant_line_high_prio_oe),
		.i_drive_next (drive_hp),
		.o_pulse_seen (seen_hp)
	);

	bmx_rg_line u_line_lp (
		.i_sys_clk    (i_sys_clk),
		.i_reset      (i_reset),
		.i_line       (i_req_grant_line_low_prio),
		.o_line       (o_req_grant_line_low_prio),
		.o_line_oe    (o_req_grant_line_low_prio_oe),
		.i_drive_next (drive_lp),
		.o_pulse_seen (seen_lp)
	);

	always_comb begin
		state_d   = state_q;
		pend_hp_d = pend_hp_q | req_hp;
		pend_lp_d = pend_lp_q | req_lp;
		sel_lp_d  = sel_lp_q;
		early_d   = early_q | (any_req & ph_early) | (win_on & ph_t1);
		win_d     = win_on ? win_q - 2'h1 : win_q;
		if (any_req & ph_idle) begin
			win_d = bmx_pkg::IDLE_WINDOW;
		end
		case (state_q)
			bmx_pkg::ST_OWN: begin
				if (pend_hp_q | pend_lp_q) begin
					state_d = bmx_pkg::ST_WAIT;
				end
			end
			bmx_pkg::ST_WAIT: begin
				if (go) begin
					// Priority decided at the grant, not at arrival
					state_d  = bmx_pkg::ST_PULSE;
					sel_lp_d = ~pend_hp_q;
					early_d  = 1'h0;
					win_d    = 2'h0;
					if (pend_hp_q) begin
						pend_hp_d = req_hp;
					end else begin
						pend_lp_d = req_lp;
					end
				end else if (ph_t4) begin
					// Missed this cycle: next one counts as early
					early_d = 1'h1;
				end
			end
			bmx_pkg::ST_PULSE: begin
				state_d = bmx_pkg::ST_GRANT;
			end
			bmx_pkg::ST_GRANT: begin
				if (rel_seen) begin
					state_d = bmx_pkg::ST_GAP;
				end
			end
			bmx_pkg::ST_GAP: begin
				state_d = bmx_pkg::ST_OWN;
			end
			default: begin
				state_d = bmx_pkg::ST_OWN;
			end
		endcase
		if (!max_q) begin
			state_d   = bmx_pkg::ST_OWN;
			pend_hp_d = 1'h0;
			pend_lp_d = 1'h0;
			early_d   = 1'h0;
			win_d     = 2'h0;
		end
	end

	// Prefix lock: set wins over the completion of the locked instruction
	assign ilock_d = max_q & (i_lock_prefix | (ilock_q & ~i_instr_done));

	// Interrupt acknowledge lock, loaded from the first-ack flag at T2 of each ack cycle
	wire ack_t2 = max_q & ph_t2 & i_irq_ack_strobe;
	assign alock_d = ack_t2 ? i_irq_ack_first : (alock_q & max_q);

	wire lock_act = ilock_d | alock_d;

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			state_q   <= bmx_pkg::ST_OWN;
			max_q     <= 1'h0;
			pend_hp_q <= 1'h0;
			pend_lp_q <= 1'h0;
			sel_lp_q  <= 1'h0;
			early_q   <= 1'h0;
			win_q     <= 2'h0;
			ilock_q   <= 1'h0;
			alock_q   <= 1'h0;
		end else begin
			state_q   <= state_d;
			max_q     <= (i_min_max_select == bmx_pkg::MODE_MAX);
			pend_hp_q <= pend_hp_d;
			pend_lp_q <= pend_lp_d;
			sel_lp_q  <= sel_lp_d;
			early_q   <= early_d;
			win_q     <= win_d;
			ilock_q   <= ilock_d;
			alock_q   <= alock_d;
		end
	end

	// Pin and handshake registers
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			bus_float_q  <= 1'h0;
			reclaim_t4_q <= 1'h0;
			reclaim_t1_q <= 1'h0;
			lock_n_q     <= bmx_pkg::PIN_HIGH;
			lock_oe_q    <= 1'h0;
			qs_q         <= bmx_pkg::QS_NOP;
			cs_q         <= bmx_pkg::STATUS_PASSIVE;
			cs_oe_q      <= 1'h0;
			high_oe_q    <= 1'h0;
		end else begin
			bus_float_q  <= float_d;
			reclaim_t4_q <= rel_seen & i_cycle_pending;
			reclaim_t1_q <= rel_seen & ~i_cycle_pending;
			lock_n_q     <= float_d | ~lock_act;
			lock_oe_q    <= max_q & ~float_d;
			qs_q         <= max_q ? qs_encode(i_q_first, i_q_subseq, i_q_flush) : bmx_pkg::QS_NOP;
			cs_q         <= float_d ? bmx_pkg::STATUS_PASSIVE : i_cycle_status;
			cs_oe_q      <= ~float_d;
			high_oe_q    <= max_q & ~float_d;
		end
	end

	assign o_bus_float          = bus_float_q;
	assign o_reclaim_t4         = reclaim_t4_q;
	assign o_reclaim_t1         = reclaim_t1_q;
	assign o_lock_n             = lock_n_q;
	assign o_lock_oe            = lock_oe_q;
	assign o_queue_state_upper  = qs_q[1];
	assign o_queue_state_lower  = qs_q[0];
	assign o_cycle_status_bit_c = cs_q[2];
	assign o_cycle_status_bit_b = cs_q[1];
	assign o_cycle_status_bit_a = cs_q[0];
	assign o_cycle_status_oe    = cs_oe_q;
	assign o_const_high         = bmx_pkg::PIN_HIGH;
	assign o_const_high_oe      = high_oe_q;

endmodule // bmx_exchange

// ==== verif/bmx_exchange_properties.sv ====
`timescale 1ns/1ps
module bmx_exchange_props (
	// Clock and inputs
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_min_max_select,
	input wire logic i_cycle_pending,
	input wire logic i_q_flush,
	// Outputs
	input wire logic o_req_grant_line_high_prio_oe,
	input wire logic o_req_grant_line_low_prio_oe,
	input wire logic o_bus_float,
	input wire logic o_reclaim_t4,
	input wire logic o_reclaim_t1,
	input wire logic o_lock_n,
	input wire logic o_lock_oe,
	input wire logic o_queue_state_upper,
	input wire logic o_queue_state_lower,
	input wire logic o_cycle_status_bit_a,
	input wire logic o_cycle_status_bit_b,
	input wire logic o_cycle_status_bit_c,
	input wire logic o_cycle_status_oe,
	input wire logic o_const_high,
	input wire logic o_const_high_oe
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	wire logic hp = o_req_grant_line_high_prio_oe;
	wire logic lp = o_req_grant_line_low_prio_oe;
	// Strap must be settled one edge before max-mode codes appear
	sequence s_max; !$past(i_reset) && !$past(i_min_max_select) && !i_min_max_select; endsequence
	property p_grant; hp |-> o_bus_float ##1 (o_bus_float && !hp); endproperty
	a_grant: assert property (p_grant) else $error("grant pulse bad");
	property p_lock_fl; o_bus_float |-> o_lock_n && !o_lock_oe; endproperty
	a_lock_fl: assert property (p_lock_fl) else $error("lock driven in grant");
	property p_stat_fl;
		o_bus_float |-> !o_cycle_status_oe &&
			{o_cycle_status_bit_c, o_cycle_status_bit_b, o_cycle_status_bit_a} == 3'h7;
	endproperty
	a_stat_fl: assert property (p_stat_fl) else $error("status not passive");
	property p_const; o_const_high and (o_bus_float |-> !o_const_high_oe); endproperty
	a_const: assert property (p_const) else $error("const pin bad");
	property p_qs; s_max ##0 i_q_flush |=> {o_queue_state_upper, o_queue_state_lower} == 2'h2; endproperty
	a_qs: assert property (p_qs) else $error("flush code bad");
	property p_reclaim;
		o_reclaim_t4 || o_reclaim_t1 |->
			$past(o_bus_float) && !o_bus_float && o_reclaim_t4 == $past(i_cycle_pending);
	endproperty
	a_reclaim: assert property (p_reclaim) else $error("reclaim bad");
	property p_gap; $fell(o_bus_float) |-> !hp && !lp ##1 !hp && !lp; endproperty
	a_gap: assert property (p_gap) else $error("no idle gap");
	property p_excl; !(hp && lp); endproperty
	a_excl: assert property (p_excl) else $error("two grants");
	c_hp: cover property (hp);
	c_lp: cover property (lp);
	c_t4: cover property (o_reclaim_t4);
endmodule // bmx_exchange_props

bind bmx_exchange bmx_exchange_props i_bmx_exchange_props (.*);

// ==== verif/bmx_master_model.sv ====
`timescale 1ns/1ps
module bmx_master_model (
	// Clock and command
	input  wire logic i_sys_clk,
	input  wire logic i_pulse,
	// Line pull-down
	output logic      o_pull_low
);
	// Low for one clock per command, released otherwise
	always_ff @(posedge i_sys_clk) begin
		o_pull_low <= i_pulse;
	end
endmodule // bmx_master_model

// ==== verif/bmx_exchange_bench.sv ====
`timescale 1ns/1ps
module bmx_exchange_bench;
	logic       clk = 1'h0, rst = 1'h1, sel = 1'h0, lowb = 1'h0, ack = 1'h0, ackf = 1'h0;
	logic       pend = 1'h0, lockp = 1'h0, done = 1'h0, qf = 1'h0, qs = 1'h0, qfl = 1'h0;
	logic [2:0] ph = 3'h0, cs = 3'h5;
	logic [1:0] cmd = 2'h0, pl;
	logic       hp_o, hp_oe, lp_o, lp_oe, flt, rt4, rt1, lk, lk_oe, qu, ql, sa, sb, sc, s_oe, ch, ch_oe;
	int         error_cnt = 0, compares = 0, gcnt = 0, k;
	wire logic  line_h = (hp_oe ? hp_o : 1'h1) & ~pl[0];
	wire logic  line_l = (lp_oe ? lp_o : 1'h1) & ~pl[1];
	wire [1:0]  oe = {lp_oe, hp_oe};
	logic [4:0] qt [5] = '{5'h00, 5'h11, 5'h0B, 5'h06, 5'h16};
	always #2 clk = ~clk;
	always @(posedge clk) if (hp_oe === 1'h1) gcnt++;
	bmx_master_model i_bmx_master_model_hp (.i_sys_clk(clk), .i_pulse(cmd[0]), .o_pull_low(pl[0]));
	bmx_master_model i_bmx_master_model_lp (.i_sys_clk(clk), .i_pulse(cmd[1]), .o_pull_low(pl[1]));
	bmx_exchange i_bmx_exchange (.i_sys_clk(clk), .i_reset(rst), .i_min_max_select(sel),
		.i_bus_phase(ph), .i_mem_cycle(1'h1), .i_low_byte_of_word(lowb), .i_irq_ack_strobe(ack),
		.i_irq_ack_first(ackf), .i_cycle_pending(pend), .i_cycle_status(cs),
		.i_lock_prefix(lockp), .i_instr_done(done), .i_q_first(qf), .i_q_subseq(qs),
		.i_q_flush(qfl), .i_req_grant_line_high_prio(line_h), .o_req_grant_line_high_prio(hp_o),
		.o_req_grant_line_high_prio_oe(hp_oe), .i_req_grant_line_low_prio(line_l),
		.o_req_grant_line_low_prio(lp_o), .o_req_grant_line_low_prio_oe(lp_oe),
		.o_bus_float(flt), .o_reclaim_t4(rt4), .o_reclaim_t1(rt1), .o_lock_n(lk),
		.o_lock_oe(lk_oe), .o_queue_state_upper(qu), .o_queue_state_lower(ql),
		.o_cycle_status_bit_a(sa), .o_cycle_status_bit_b(sb), .o_cycle_status_bit_c(sc),
		.o_cycle_status_oe(s_oe), .o_const_high(ch), .o_const_high_oe(ch_oe));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic rchk;
		chk({oe, flt, rt4, rt1, lk, lk_oe, s_oe}, 8'h04);
		chk({sc, sb, sa, qu, ql, ch_oe}, 8'h38);
	endtask
	task automatic req(input logic [1:0] m);
		@(posedge clk) cmd <= m;
		@(posedge clk) cmd <= 2'h0;
	endtask
	// Partner holds the bus a few cycles, a slow answer
	task automatic grant(input int i, input logic pv);
		k = 0;
		while (oe[i] !== 1'h1 && k < 12) begin
			@(posedge clk) #1 k++;
		end
		chk(k < 12, 8'h01);
		chk({flt, ch_oe, lk_oe, s_oe, ~lk, sc, sb, sa}, 8'h87);
		@(posedge clk) #1 chk({oe, flt}, 8'h01);
		repeat (3) @(posedge clk);
		pend <= pv;
		req(2'h1 << i);
		k = 0;
		while ((rt4 | rt1) !== 1'h1 && k < 6) begin
			@(posedge clk) #1 k++;
		end
		chk({rt4, rt1, flt}, {pv, ~pv, 1'h0});
	endtask
	task automatic cyc(input logic lb, input logic r);
		for (int p = 1; p < 5; p++) begin
			@(posedge clk) ph <= p[2:0];
			lowb <= lb;
			cmd[0] <= r && p == 1;
		end
	endtask
	initial begin
		repeat (10) @(posedge clk);
		#1 rchk();
		@(posedge clk) rst <= 1'h0;
		repeat (2) @(posedge clk);
		for (int r = 0; r < 5; r++) begin
			@(posedge clk) {qf, qs, qfl} <= qt[r][4:2];
			@(posedge clk) {qf, qs, qfl} <= 3'h0;
			#1 chk({qu, ql}, qt[r][1:0]);
		end
		chk({s_oe, sc, sb, sa, ch, ch_oe, lk_oe}, 8'h6F);
		req(2'h1);
		grant(0, 1'h0);
		req(2'h2);
		grant(1, 1'h1);
		req(2'h3);
		grant(0, 1'h0);
		grant(1, 1'h0);
		k = gcnt;
		cyc(1'h1, 1'h1);
		cyc(1'h0, 1'h0);
		chk(gcnt - k, 8'h00);
		@(posedge clk) ph <= 3'h0;
		#1 chk(hp_oe, 8'h01);
		grant(0, 1'h1);
		@(posedge clk) lockp <= 1'h1;
		@(posedge clk) lockp <= 1'h0;
		repeat (3) @(posedge clk);
		done <= 1'h1;
		#1 chk(lk, 8'h00);
		@(posedge clk) done <= 1'h0;
		#1 chk(lk, 8'h01);
		@(posedge clk) {ph, ack, ackf} <= 5'h0B;
		@(posedge clk) ph <= 3'h3;
		#1 chk(lk, 8'h00);
		@(posedge clk) {ph, ackf} <= 4'h4;
		@(posedge clk) {ph, ack} <= 4'h0;
		#1 chk(lk, 8'h01);
		// Idle-bus request, then a cycle starts: granted at its first T4
		req(2'h1);
		cyc(1'h0, 1'h0);
		@(posedge clk) ph <= 3'h0;
		#1 chk(hp_oe, 8'h01);
		grant(0, 1'h0);
		@(posedge clk) sel <= 1'h1;
		repeat (2) @(posedge clk);
		k = gcnt;
		req(2'h1);
		repeat (8) @(posedge clk);
		#1 chk(gcnt - k, 8'h00);
		chk(lk_oe, 8'h00);
		@(posedge clk) rst <= 1'h1;
		repeat (2) @(posedge clk);
		#1 rchk();
		results();
	end
	initial begin
		#40000;
		error_cnt++;
		results();
	end
endmodule // bmx_exchange_bench
